// >>> batt_pkg.sv
// Register map, field positions and reset values of the status and alarm bank
package batt_pkg;
   // Register byte addresses on the APB
   localparam logic [7:0] status_addr    = 8'h00;
   localparam logic [7:0] alarm_addr     = 8'h04;
   localparam logic [7:0] mask_addr      = 8'h08;
   localparam logic [7:0] cmd_addr       = 8'h0c;
   localparam logic [7:0] config_addr    = 8'h10;
   localparam logic [7:0] reject_addr    = 8'h14;
   // Battery status word field positions
   localparam int cfg_change_bit   = 5;
   localparam int irq_level_bit    = 4;
   localparam int charge_bit       = 3;
   localparam int discharge_bit    = 2;
   localparam int chg_detect_bit   = 1;
   // Alarm word field positions
   localparam int safety_a_bit     = 15;
   localparam int toggle_bit       = 1;
   // Command register codes
   localparam logic [1:0] cmd_enter = 2'h1;
   localparam logic [1:0] cmd_exit  = 2'h2;
   // Reset values
   localparam logic [15:0] mask_reset   = 16'hffff;
   localparam logic [15:0] config_reset = 16'h0000;
   // Cycles the enter command takes to be processed
   localparam int enter_proc_cycles = 4;
endpackage

// >>> batt_alarm_latch.sv
// Sixteen write-one-to-clear alarm latches, one per alarm bit
`timescale 1ns/1ps
module batt_alarm_latch #(
   parameter int width = 16
) (
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Set and clear requests
   input  wire logic [width-1:0] set_req,
   input  wire logic [width-1:0] clr_req,
   // Latched value
   output logic      [width-1:0] latched
);
   typedef struct packed {
      logic [width-1:0] bits;
   } latch_state_t;

   latch_state_t st_r;
   latch_state_t st_nxt;

   // Set wins over a clear in the same cycle, so no event is lost
   always_comb begin
      st_nxt = st_r;
      for (int i = 0; i < width; i++) begin
         if (set_req[i]) begin
            st_nxt.bits[i] = 1'b1;
         end else if (clr_req[i]) begin
            st_nxt.bits[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign latched = st_r.bits;

   a_latch_holds: assert property (
      @(posedge pclk) disable iff (!presetn)
      (latched[0] && !clr_req[0]) |=> latched[0])
      else $error("alarm latch lost its value without a clear");
endmodule

// >>> batt_status_bank.sv
// Battery status word and alarm latch bank on an APB slave
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// What this block does
// - Config-change flag sets only after enter command fully processed
// - Config writes accepted only while the config-change flag is one
// - Status bit 4 reads one while the interrupt pin is pulled low
// - Status bit 3 shows whether the charge driver is enabled
// - Status bit 2 shows whether the discharge driver is enabled
// - Status bit 1 shows the debounced charger-detect level
// - Alarm bits hold until the host writes one to them
// - Alarm bit 15 latches on any safety fault group A bit while mask bit 15 is one
// - Any set alarm bit drives the interrupt pin low
// - Toggle alarm latches when debounced charger-detect level changes
module batt_status_bank (
   // APB clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Device state
   input  wire logic        charge_driver,
   input  wire logic        discharge_driver,
   input  wire logic        charger_detect_level,
   input  wire logic [15:0] safety_fault_a,
   input  wire logic [15:0] other_alarm_set,
   // Interrupt pin, open drain
   output logic             irq_o,
   output logic             irq_oe,
   // Configuration out
   output logic [15:0]      config_word
);
   ////////////////////////////////////////////////////////////////////////
   typedef enum logic [2:0] {
      cm_idle  = 3'b001,
      cm_busy  = 3'b010,
      cm_on    = 3'b100
   } cfg_mode_t;

   typedef struct packed {
      cfg_mode_t   mode;
      logic [2:0]  proc_cnt;
      logic [15:0] mask;
      logic [15:0] config_w;
      logic        rejected;
      logic        chg_det_prev;
      logic        chg_det_seen;
      logic        charge;
      logic        discharge;
      logic        irq_low;
      logic [31:0] rdata;
      logic        ready;
      logic        slverr;
   } bank_state_t;

   bank_state_t st_r;
   bank_state_t st_nxt;

   logic [15:0] alarm_set;
   logic [15:0] alarm_clr;
   logic [15:0] alarms;
   logic        wr_acc;
   logic        rd_acc;
   logic        mapped;
   logic [15:0] status_word;

   localparam logic [2:0] proc_last =
      3'(batt_pkg::enter_proc_cycles - 1);

   // Access phase takes two cycles: pready goes high the cycle after the
   // first access-phase cycle and the transfer ends there
   assign wr_acc = psel && penable && !st_r.ready && pwrite;
   assign rd_acc = psel && penable && !st_r.ready && !pwrite;
   assign mapped = (paddr == batt_pkg::status_addr) ||
                   (paddr == batt_pkg::alarm_addr)  ||
                   (paddr == batt_pkg::mask_addr)   ||
                   (paddr == batt_pkg::cmd_addr)    ||
                   (paddr == batt_pkg::config_addr) ||
                   (paddr == batt_pkg::reject_addr);

   ////////////////////////////////////////////////////////////////////////
   // Alarm triggers; other bits come from sources outside this bank
   always_comb begin
      alarm_set = other_alarm_set & st_r.mask;
      alarm_set[batt_pkg::safety_a_bit] =
         (|safety_fault_a) && st_r.mask[batt_pkg::safety_a_bit];
      alarm_set[batt_pkg::toggle_bit] = st_r.chg_det_seen &&
         (charger_detect_level != st_r.chg_det_prev);
      // Only ones written clear; zeros leave the latch alone
      alarm_clr = (wr_acc && paddr == batt_pkg::alarm_addr) ?
                  pwdata[15:0] : 16'h0000;
   end

   batt_alarm_latch #(
      .width(16)
   ) u_latch (
      .pclk    (pclk),
      .presetn (presetn),
      .set_req (alarm_set),
      .clr_req (alarm_clr),
      .latched (alarms)
   );

   ////////////////////////////////////////////////////////////////////////
   // Live status word seen by software
   always_comb begin
      status_word = 16'h0000;
      status_word[batt_pkg::cfg_change_bit] = (st_r.mode == cm_on);
      status_word[batt_pkg::irq_level_bit]  = st_r.irq_low;
      status_word[batt_pkg::charge_bit]     = st_r.charge;
      status_word[batt_pkg::discharge_bit]  = st_r.discharge;
      status_word[batt_pkg::chg_detect_bit] = st_r.chg_det_prev;
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state of the whole bank
   always_comb begin
      st_nxt = st_r;
      st_nxt.ready  = 1'b0;
      st_nxt.slverr = 1'b0;
      st_nxt.charge       = charge_driver;
      st_nxt.discharge    = discharge_driver;
      st_nxt.chg_det_prev = charger_detect_level;
      st_nxt.chg_det_seen = 1'b1;
      // Pin follows the latches a cycle behind; released when all clear
      st_nxt.irq_low = |alarms;
      // Enter command completes only after its processing delay
      unique case (st_r.mode)
         cm_idle: begin
            st_nxt.proc_cnt = 3'h0;
         end
         cm_busy: begin
            if (st_r.proc_cnt == proc_last) begin
               st_nxt.mode = cm_on;
            end else begin
               st_nxt.proc_cnt = st_r.proc_cnt + 3'h1;
            end
         end
         cm_on: begin
            st_nxt.proc_cnt = 3'h0;
         end
      endcase
      if (psel && penable && !st_r.ready) begin
         st_nxt.ready  = 1'b1;
         st_nxt.slverr = !mapped;
         st_nxt.rdata  = 32'h0000_0000;
      end
      if (rd_acc) begin
         unique case (1'b1)
            paddr == batt_pkg::status_addr:
               st_nxt.rdata = {16'h0000, status_word};
            paddr == batt_pkg::alarm_addr:
               st_nxt.rdata = {16'h0000, alarms};
            paddr == batt_pkg::mask_addr:
               st_nxt.rdata = {16'h0000, st_r.mask};
            paddr == batt_pkg::config_addr:
               st_nxt.rdata = {16'h0000, st_r.config_w};
            paddr == batt_pkg::reject_addr:
               st_nxt.rdata = {31'h0, st_r.rejected};
            default:
               st_nxt.rdata = 32'h0000_0000;
         endcase
      end
      if (wr_acc) begin
         if (paddr == batt_pkg::mask_addr) begin
            st_nxt.mask = pwdata[15:0];
         end
         if (paddr == batt_pkg::cmd_addr) begin
            if (pwdata[1:0] == batt_pkg::cmd_enter &&
                st_r.mode == cm_idle) begin
               st_nxt.mode = cm_busy;
            end else if (pwdata[1:0] == batt_pkg::cmd_exit) begin
               st_nxt.mode = cm_idle;
            end
         end
         if (paddr == batt_pkg::reject_addr && pwdata[0]) begin
            st_nxt.rejected = 1'b0;
         end
         if (paddr == batt_pkg::config_addr) begin
            if (st_r.mode == cm_on) begin
               st_nxt.config_w = pwdata[15:0];
            end else begin
               st_nxt.rejected = 1'b1;
            end
         end
      end
   end

   // Single register stage for all state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r.mode         <= cm_idle;
         st_r.proc_cnt     <= 3'h0;
         st_r.mask         <= batt_pkg::mask_reset;
         st_r.config_w     <= batt_pkg::config_reset;
         st_r.rejected     <= 1'b0;
         st_r.chg_det_prev <= 1'b0;
         st_r.chg_det_seen <= 1'b0;
         st_r.charge       <= 1'b0;
         st_r.discharge    <= 1'b0;
         st_r.irq_low      <= 1'b0;
         st_r.rdata        <= 32'h0000_0000;
         st_r.ready        <= 1'b0;
         st_r.slverr       <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs straight from flip-flops; pin only ever driven low
   assign prdata      = st_r.rdata;
   assign pready      = st_r.ready;
   assign pslverr     = st_r.slverr;
   assign irq_o       = 1'b0;
   assign irq_oe      = st_r.irq_low;
   assign config_word = st_r.config_w;

   ////////////////////////////////////////////////////////////////////////
   // Enter command taken while idle; only this starts the processing
   sequence s_enter_cmd;
      wr_acc && paddr == batt_pkg::cmd_addr &&
      pwdata[1:0] == batt_pkg::cmd_enter && st_r.mode == cm_idle;
   endsequence

   // Flag stays low for the whole processing time, then rises
   sequence s_enter_done;
      (st_r.mode != cm_on) [*4] ##1 (st_r.mode == cm_on);
   endsequence

   // Latch first, pin a cycle later, as the pin stage is registered
   sequence s_safety_seen;
      alarms[batt_pkg::safety_a_bit] ##1 irq_oe;
   endsequence

   ////////////////////////////////////////////////////////////////////////
   // Configuration mode and its gate
   a_cfg_flag_delay: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_enter_cmd |=> s_enter_done)
      else $error("config flag timing wrong");
   a_cfg_write_gate: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_acc && paddr == batt_pkg::config_addr && st_r.mode != cm_on)
      |=> $stable(config_word) && st_r.rejected)
      else $error("config write accepted outside config mode");
   a_cfg_write_take: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_acc && paddr == batt_pkg::config_addr && st_r.mode == cm_on)
      |=> config_word == 16'($past(pwdata)))
      else $error("config write lost in config mode");

   ////////////////////////////////////////////////////////////////////////
   // Status word: pin bit checked through the read path, charge, discharge and detect bits on status_word
   a_irq_status: assert property (
      @(posedge pclk) disable iff (!presetn)
      (rd_acc && paddr == batt_pkg::status_addr)
      |=> prdata[batt_pkg::irq_level_bit] == $past(irq_oe))
      else $error("status pin bit disagrees with pin");
   a_charge_bit: assert property (
      @(posedge pclk) disable iff (!presetn)
      ##1 status_word[batt_pkg::charge_bit] == $past(charge_driver))
      else $error("charge bit wrong");
   a_dsg_bit: assert property (
      @(posedge pclk) disable iff (!presetn)
      ##1 status_word[batt_pkg::discharge_bit] == $past(discharge_driver))
      else $error("discharge bit wrong");
   a_detect_bit: assert property (
      @(posedge pclk) disable iff (!presetn)
      ##1 status_word[batt_pkg::chg_detect_bit] ==
      $past(charger_detect_level))
      else $error("charger detect bit wrong");

   ////////////////////////////////////////////////////////////////////////
   // Alarm triggers, clears and the pin
   a_safety_latch: assert property (
      @(posedge pclk) disable iff (!presetn)
      ((|safety_fault_a) && st_r.mask[batt_pkg::safety_a_bit])
      |=> s_safety_seen)
      else $error("safety alarm not latched");
   a_safety_masked: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!st_r.mask[batt_pkg::safety_a_bit] &&
      !alarms[batt_pkg::safety_a_bit])
      |=> !alarms[batt_pkg::safety_a_bit])
      else $error("masked safety alarm latched");
   a_toggle_latch: assert property (
      @(posedge pclk) disable iff (!presetn)
      (st_r.chg_det_seen && charger_detect_level != st_r.chg_det_prev)
      |=> alarms[batt_pkg::toggle_bit])
      else $error("toggle alarm not latched");
   a_irq_drive: assert property (
      @(posedge pclk) disable iff (!presetn)
      (|alarms) |=> irq_oe)
      else $error("pin not pulled low with an alarm set");
   a_irq_release: assert property (
      @(posedge pclk) disable iff (!presetn)
      (alarms == 16'h0000) |=> !irq_oe)
      else $error("pin not released after clear");
   a_zero_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      (alarms[0] && !alarm_clr[0]) |=> alarms[0])
      else $error("alarm cleared without a one");
   a_w1c_clear: assert property (
      @(posedge pclk) disable iff (!presetn)
      (alarm_clr[0] && !alarm_set[0]) |=> !alarms[0])
      else $error("alarm not cleared by a one");

   ////////////////////////////////////////////////////////////////////////
   // Bus answer: a one-cycle pulse, error and zero data when unmapped
   a_ready_pulse: assert property (
      @(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("ready held for more than one cycle");
   a_unmapped_err: assert property (
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready && !mapped)
      |=> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not refused");
endmodule

// >>> batt_host_model.sv
// Host processor model: APB master that reads status and clears alarms
`timescale 1ns/1ps
module batt_host_model (
   // Clock
   input  wire logic        pclk,
   // APB master side
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   ////////////////////////////////////////////////////////////////////////
   // Idle bus at time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end

   // One transfer; waits on pready, so any slave latency is accepted
   task automatic xfer(input logic wr, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q, output logic err);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;  // Ones written to alarms clear them
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released lines flip so a stale value can never be taken as valid
      paddr <= ~a;
      pwdata <= ~d;
      @(posedge pclk);
   endtask
endmodule

// >>> test_batt_status_bank.sv
// Self-checking bench for the battery status and alarm latch bank
`timescale 1ns/1ps
module test_batt_status_bank;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic        charge_driver = 1'b0;
   logic        discharge_driver = 1'b0;
   logic        charger_detect_level = 1'b0;
   logic        nd, cfg_m = 1'b0;
   logic [15:0] safety_fault_a = 16'h0, other_alarm_set = 16'h0;
   logic [15:0] config_word, alarm_m = 16'h0, mask_m = 16'hffff, w;
   logic        irq_o, irq_oe, irq_line;
   int          errors = 0, checks_done = 0, cycles = 0;

   ////////////////////////////////////////////////////////////////////////
   // Clock, pulled-up open-drain pin and hang guard
   always #50 pclk = ~pclk;
   assign irq_line = irq_oe ? irq_o : 1'b1;
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         end_of_test();
      end
   end

   batt_host_model i_batt_host_model (.pclk(pclk), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   batt_status_bank i_batt_status_bank (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .charge_driver(charge_driver),
      .discharge_driver(discharge_driver),
      .charger_detect_level(charger_detect_level),
      .safety_fault_a(safety_fault_a), .other_alarm_set(other_alarm_set),
      .irq_o(irq_o), .irq_oe(irq_oe), .config_word(config_word));

   ////////////////////////////////////////////////////////////////////////
   // Comparison, bus and stimulus helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_batt_host_model.xfer(1'b1, a, d, q, err);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      i_batt_host_model.xfer(1'b0, a, 32'h0, q, err);
      check(q, exp);
   endtask
   function automatic logic [31:0] stat_exp();
      return {26'h0, cfg_m, alarm_m != 16'h0, charge_driver,
         discharge_driver, charger_detect_level, 1'b0};
   endfunction
   // Pin must be low exactly while some alarm is latched
   task automatic pin_chk();
      check(32'(irq_line), 32'(alarm_m == 16'h0));
   endtask
   // One-cycle trigger pulse; the model latches what the mask lets pass
   task automatic pulse(input logic [15:0] fa, input logic [15:0] oth);
      safety_fault_a <= fa;
      other_alarm_set <= oth;
      @(posedge pclk);
      safety_fault_a <= 16'h0;
      other_alarm_set <= 16'h0;
      repeat (2) @(posedge pclk);
      if (fa != 16'h0 && mask_m[15]) alarm_m[15] = 1'b1;
      alarm_m |= oth & mask_m & 16'h7ffd;
   endtask
   task automatic clear(input logic [15:0] c);
      wr(batt_pkg::alarm_addr, {16'h0, c});
      alarm_m &= ~c;
   endtask
   task automatic end_of_test();
      $display("Checks %0d, errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      void'($urandom(32'h92ff8e96));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(batt_pkg::mask_addr, 32'hffff);
      rd(batt_pkg::config_addr, 32'h0);
      // Random driver levels; detect edges latch the toggle alarm
      repeat (8) begin
         nd = 1'($urandom);
         if (nd != charger_detect_level) alarm_m[1] = 1'b1;
         charge_driver <= 1'($urandom);
         discharge_driver <= 1'($urandom);
         charger_detect_level <= nd;
         repeat (4) @(posedge pclk);
         rd(batt_pkg::status_addr, stat_exp());
         rd(batt_pkg::alarm_addr, {16'h0, alarm_m});
         pin_chk();
      end
      // Status is read-only
      wr(batt_pkg::status_addr, 32'hffff);
      rd(batt_pkg::status_addr, stat_exp());
      clear(16'hffff);
      rd(batt_pkg::alarm_addr, 32'h0);
      pin_chk();
      // Safety fault latch, held after the cause is gone, zero writes
      pulse(16'h0001 << $urandom_range(15), 16'h0);
      rd(batt_pkg::alarm_addr, {16'h0, alarm_m});
      rd(batt_pkg::status_addr, stat_exp());
      pin_chk();
      wr(batt_pkg::alarm_addr, 32'h0);
      rd(batt_pkg::alarm_addr, {16'h0, alarm_m});
      clear(16'h8000);
      rd(batt_pkg::alarm_addr, 32'h0);
      pin_chk();
      // Masked triggers and partial clears
      mask_m = 16'h7fff;
      wr(batt_pkg::mask_addr, {16'h0, mask_m});
      repeat (4) begin
         pulse(16'hffff, 16'($urandom));
         rd(batt_pkg::alarm_addr, {16'h0, alarm_m});
         pin_chk();
         w = 16'($urandom);
         clear(w);
         rd(batt_pkg::alarm_addr, {16'h0, alarm_m});
      end
      clear(16'hffff);
      repeat (2) @(posedge pclk);
      pin_chk();
      // Configuration gating by the enter and exit commands
      wr(batt_pkg::config_addr, 32'h1234);
      rd(batt_pkg::config_addr, 32'h0);
      rd(batt_pkg::reject_addr, 32'h1);
      wr(batt_pkg::reject_addr, 32'h1);
      rd(batt_pkg::reject_addr, 32'h0);
      wr(batt_pkg::cmd_addr, {30'h0, batt_pkg::cmd_enter});
      rd(batt_pkg::status_addr, stat_exp());
      repeat (6) @(posedge pclk);
      cfg_m = 1'b1;
      rd(batt_pkg::status_addr, stat_exp());
      wr(batt_pkg::config_addr, 32'h1234);
      rd(batt_pkg::config_addr, 32'h1234);
      check(32'(config_word), 32'h1234);
      wr(batt_pkg::cmd_addr, {30'h0, batt_pkg::cmd_exit});
      repeat (6) @(posedge pclk);
      cfg_m = 1'b0;
      wr(batt_pkg::config_addr, 32'h5555);
      rd(batt_pkg::config_addr, 32'h1234);
      rd(batt_pkg::reject_addr, 32'h1);
      // Unmapped address answers with an error and zero data
      i_batt_host_model.xfer(1'b0, 8'h20, 32'h0, q, err);
      check({q[31:1], err}, 32'h1);
      end_of_test();
   end
endmodule
